// file: rtl/dcim_matrix.sv
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - each core gets 32 lines, 26 peripheral
// - routable lines 0-5,8-10,12-14,17-28,30-31
// - lines 6,7,11,15,16,29 never reached
// - lines 10,22,28,30 edge; 14 non-maskable
// - fixed priority per line, levels one to five, seven on nmi line 14
// - separate independent route per source per core
// - peripheral route drives that core line
// - internal route disconnects the source, any number
// - shared line is OR of its sources
// - nmi mask blocks sources on line 14
// - raw source state readable per core
// - source n at word n/32, bit n%32
module dcim_matrix #(
	parameter int NUM_SRC = dcim_pkg::DCIM_SRC_DEF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// peripheral sources
	input wire logic [NUM_SRC-1:0] src_i,
	// nmi masks from the process_id_controller
	input wire logic [1:0] nmi_mask_i,
	// core lines
	output logic [31:0] first_core_line,
	output logic [31:0] second_core_line,
	// interrupt
	output logic irq
);
	// number of 32-bit state words per core
	localparam int SW = (NUM_SRC + 31) / 32;
	localparam int SW_BYTES = SW * 4;

	// routing store, one five-bit line number per source per core
	logic [1:0][NUM_SRC-1:0][4:0] route_r;
	// bus state
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	// combined request and decode results
	dcim_pkg::dcim_apb_req_t req;
	logic [31:0] rd_data;
	logic hit;
	logic wr_go;
	logic [1:0] route_we;
	logic [6:0] src_idx;
	logic [4:0] line_idx;
	logic [NUM_SRC-1:0] route_sel_ok;
	// zero-padded source image for state words
	logic [SW*32-1:0] src_pad;
	// combinational core lines and events
	logic [1:0][31:0] map_lines;
	logic [1:0] nmi_hit;
	logic [dcim_pkg::DCIM_EV_W-1:0] ev;
	logic [dcim_pkg::DCIM_EV_W-1:0] ev_stat;
	logic [dcim_pkg::DCIM_EV_W-1:0] ev_en;
	logic irq_w;
	// registered core lines
	logic [31:0] line0_r;
	logic [31:0] line1_r;

	// gather bus fields into one request word
	always_comb begin
		req.addr = paddr;
		req.write = pwrite;
		req.wdata = pwdata;
	end

	// index fields shared by route and priority windows
	assign src_idx = req.addr[8:2];
	assign line_idx = req.addr[6:2];

	// pad so every state word is a full 32 bits
	always_comb begin
		src_pad = '0;
		src_pad[NUM_SRC-1:0] = src_i;
	end

	// one-hot valid flag per source index
	always_comb begin
		route_sel_ok = '0;
		for (int s = 0; s < NUM_SRC; s++) begin
			route_sel_ok[s] = (src_idx == 7'(s));
		end
	end

	// address decode and read mux
	always_comb begin
		rd_data = '0;
		hit = 1'b0;
		if (req.addr[1:0] != 2'h0) begin
			// misaligned word: refused
			hit = 1'b0;
		end else if (req.addr[11:9] == dcim_pkg::DCIM_A_ROUTE0[11:9]) begin
			hit = |route_sel_ok;
			for (int s = 0; s < NUM_SRC; s++) begin
				if (route_sel_ok[s]) begin
					rd_data = {27'h0, route_r[0][s]};
				end
			end
		end else if (req.addr[11:9] == dcim_pkg::DCIM_A_ROUTE1[11:9]) begin
			hit = |route_sel_ok;
			for (int s = 0; s < NUM_SRC; s++) begin
				if (route_sel_ok[s]) begin
					rd_data = {27'h0, route_r[1][s]};
				end
			end
		end else if (req.addr >= dcim_pkg::DCIM_A_STAT0 &&
			req.addr < dcim_pkg::DCIM_A_STAT0 + 12'(SW_BYTES)) begin
			// both cores see the same raw source level
			hit = 1'b1;
			for (int w = 0; w < SW; w++) begin
				if (req.addr[5:2] == 4'(w)) begin
					rd_data = src_pad[w*32 +: 32];
				end
			end
		end else if (req.addr >= dcim_pkg::DCIM_A_STAT1 &&
			req.addr < dcim_pkg::DCIM_A_STAT1 + 12'(SW_BYTES)) begin
			hit = 1'b1;
			for (int w = 0; w < SW; w++) begin
				if (req.addr[5:2] == 4'(w)) begin
					rd_data = src_pad[w*32 +: 32];
				end
			end
		end else if (req.addr == dcim_pkg::DCIM_A_IRQ_STAT) begin
			hit = 1'b1;
			rd_data = {29'h0, ev_stat};
		end else if (req.addr == dcim_pkg::DCIM_A_IRQ_CLR) begin
			// write-only, reads as zero
			hit = 1'b1;
		end else if (req.addr == dcim_pkg::DCIM_A_IRQ_EN) begin
			hit = 1'b1;
			rd_data = {29'h0, ev_en};
		end else if (req.addr == dcim_pkg::DCIM_A_EDGE) begin
			// which peripheral lines the core treats as edges
			hit = 1'b1;
			rd_data = dcim_pkg::DCIM_EDGE_MASK;
		end else if (req.addr == dcim_pkg::DCIM_A_PERIPH) begin
			hit = 1'b1;
			rd_data = dcim_pkg::DCIM_PERIPH_MASK;
		end else if (req.addr[11:7] == dcim_pkg::DCIM_A_PRIO[11:7]) begin
			// fixed priority table, nmi reads as seven
			hit = 1'b1;
			rd_data = {29'h0, dcim_pkg::dcim_prio(line_idx)};
		end
	end

	// write strobes land on the edge that samples pready high
	assign wr_go = psel & penable & pready_r & req.write & ~pslverr_r;
	assign route_we[0] = wr_go && req.addr[11:9] == dcim_pkg::DCIM_A_ROUTE0[11:9];
	assign route_we[1] = wr_go && req.addr[11:9] == dcim_pkg::DCIM_A_ROUTE1[11:9];

	// bus handshake: one wait-free access cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else if (psel && !penable) begin
			// setup cycle: answer is ready for the access phase
			pready_r <= 1'b1;
			pslverr_r <= ~hit;
			prdata_r <= (hit && !req.write) ? rd_data : 32'h0;
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end
	end

	// routing registers, each core bank written on its own
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_r <= {2 * NUM_SRC{dcim_pkg::DCIM_ROUTE_RST}};
		end else begin
			for (int c = 0; c < 2; c++) begin
				for (int s = 0; s < NUM_SRC; s++) begin
					if (route_we[c] && route_sel_ok[s]) begin
						route_r[c][s] <= req.wdata[4:0];
					end
				end
			end
		end
	end

	// one routing network per core, independent of the other
	for (genvar c = 0; c < 2; c++) begin : g_core
		dcim_core_map #(
			.NUM_SRC(NUM_SRC)
		) u_map (
			.src(src_i),
			.route(route_r[c]),
			.nmi_mask(nmi_mask_i[c]),
			.lines(map_lines[c]),
			.nmi_hit(nmi_hit[c])
		);
	end

	// lines are registered so the core sees clean levels and edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line0_r <= '0;
			line1_r <= '0;
		end else begin
			line0_r <= map_lines[0] & dcim_pkg::DCIM_PERIPH_MASK;
			line1_r <= map_lines[1] & dcim_pkg::DCIM_PERIPH_MASK;
		end
	end

	// events: masked nmi activity per core and refused bus access
	always_comb begin
		ev = '0;
		ev[dcim_pkg::DCIM_EV_NMI0] = nmi_hit[0];
		ev[dcim_pkg::DCIM_EV_NMI1] = nmi_hit[1];
		ev[dcim_pkg::DCIM_EV_BUSERR] = psel & penable & pready_r & pslverr_r;
	end

	// sticky status, enable and level interrupt
	dcim_irq #(
		.EW(dcim_pkg::DCIM_EV_W)
	) u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.ev(ev),
		.clr_we(wr_go && req.addr == dcim_pkg::DCIM_A_IRQ_CLR),
		.en_we(wr_go && req.addr == dcim_pkg::DCIM_A_IRQ_EN),
		.wdata(req.wdata[dcim_pkg::DCIM_EV_W-1:0]),
		.stat_r(ev_stat),
		.en_r(ev_en),
		.irq_r(irq_w)
	);

	// outputs come straight from flip-flops
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign first_core_line = line0_r;
	assign second_core_line = line1_r;
	assign irq = irq_w;

	// checks below watch the registered lines and bus answer,
	// so each one except chk_internal_quiet expects its result one edge after the cause
	// internal lines stay low on both cores
	chk_internal_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		((first_core_line | second_core_line) & ~dcim_pkg::DCIM_PERIPH_MASK) == 32'h0)
		else $error("internal line driven");

	// masked nmi line stays low one cycle later
	chk_nmi_blocked: assert property (@(posedge pclk) disable iff (!presetn)
		nmi_mask_i[0] |=> !first_core_line[14])
		else $error("nmi line passed while masked");

	// a source routed to a plain peripheral line shows on it next cycle
	chk_route_drive: assert property (@(posedge pclk) disable iff (!presetn)
		(src_i[0] && route_r[0][0] == 5'h00) |=> first_core_line[0])
		else $error("routed source not driving line");

	// OR sharing: source 2 drives line 3 while source 1 shares that line
	chk_or_share: assert property (@(posedge pclk) disable iff (!presetn)
		(src_i[2] && route_r[0][1] == 5'h03 && route_r[0][2] == 5'h03) |=>
		first_core_line[3])
		else $error("shared line not driven");

	// parked routes leave every line of the first core low
	chk_internal_route: assert property (@(posedge pclk) disable iff (!presetn)
		(route_r[0] == {NUM_SRC{dcim_pkg::DCIM_ROUTE_RST}}) |=> first_core_line == 32'h0)
		else $error("disabled source reached core");

	// pready stands for exactly one cycle
	chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready held too long");

	// a route write is stored with its five bits
	chk_route_write: assert property (@(posedge pclk) disable iff (!presetn)
		(route_we[1] && route_sel_ok[0]) |=>
		(route_r[1][0] == $past(req.wdata[4:0]) && route_r[0][0] == $past(route_r[0][0])))
		else $error("route write wrong");

	// state word read returns raw source level
	chk_state_read: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == dcim_pkg::DCIM_A_STAT0) |=>
		(prdata[0] == $past(src_i[0])))
		else $error("state word wrong");

	// second core state word carries the same raw levels
	chk_state_second: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == dcim_pkg::DCIM_A_STAT1) |=>
		(prdata == $past(src_pad[31:0])))
		else $error("second state word wrong");

	// the second core has its own route for source zero
	chk_second_route: assert property (@(posedge pclk) disable iff (!presetn)
		(src_i[0] && route_r[1][0] == 5'h1F) |=> second_core_line[31])
		else $error("second core route not driving line");

	// writing the first core's bank never disturbs the second core's bank
	chk_bank_apart: assert property (@(posedge pclk) disable iff (!presetn)
		route_we[0] |=> route_r[1] == $past(route_r[1]))
		else $error("route bank written across cores");

	// parked routes leave every line of the second core low
	chk_parked_second: assert property (@(posedge pclk) disable iff (!presetn)
		(route_r[1] == {NUM_SRC{dcim_pkg::DCIM_ROUTE_RST}}) |=> second_core_line == 32'h0)
		else $error("parked source reached second core");

	// the second core's nmi line is held back by its own mask
	chk_nmi_second: assert property (@(posedge pclk) disable iff (!presetn)
		nmi_mask_i[1] |=> !second_core_line[dcim_pkg::DCIM_NMI_LINE])
		else $error("second nmi line passed while masked");

	// an unmasked nmi source still reaches its core; masks are per core
	chk_nmi_open: assert property (@(posedge pclk) disable iff (!presetn)
		(!nmi_mask_i[0] && src_i[NUM_SRC-1] &&
		route_r[0][NUM_SRC-1] == dcim_pkg::DCIM_NMI_LINE) |=>
		first_core_line[dcim_pkg::DCIM_NMI_LINE])
		else $error("unmasked nmi line blocked");

	// a held-back nmi source leaves a sticky event for software
	chk_nmi_event: assert property (@(posedge pclk) disable iff (!presetn)
		nmi_hit[1] |=> ev_stat[dcim_pkg::DCIM_EV_NMI1])
		else $error("masked nmi not logged");

	// pready answers the access phase that follows every setup
	chk_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready)
		else $error("setup cycle not answered");

	// a refused access answers with an error flag and empty data
	chk_refused: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !hit) |=> (pready && pslverr && prdata == 32'h0))
		else $error("refused access answered wrong");

	// a refused access is logged and changes no route
	chk_refused_log: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && pslverr) |=>
		(ev_stat[dcim_pkg::DCIM_EV_BUSERR] && route_r == $past(route_r)))
		else $error("refused access not logged or not ignored");
endmodule : dcim_matrix

// file: rtl/dcim_pkg.sv
package dcim_pkg;
	// core line count and peripheral line budget per core
	localparam int DCIM_LINES = 32;
	localparam int DCIM_PERIPH_LINES = 26;
	localparam int DCIM_SRC_DEF = 69;
	localparam int DCIM_ROUTE_W = 5;
	// line classes: peripheral, edge-triggered, non-maskable
	localparam logic [31:0] DCIM_PERIPH_MASK = 32'hDFFE773F;
	localparam logic [31:0] DCIM_EDGE_MASK = 32'h50400400;
	localparam logic [4:0] DCIM_NMI_LINE = 5'h0E;
	// reset routing parks every source on an internal line
	localparam logic [4:0] DCIM_ROUTE_RST = 5'h06;
	localparam logic [2:0] DCIM_PRIO_NMI = 3'h7;
	// byte offsets on the register bus
	localparam logic [11:0] DCIM_A_ROUTE0 = 12'h000;
	localparam logic [11:0] DCIM_A_ROUTE1 = 12'h200;
	localparam logic [11:0] DCIM_A_STAT0 = 12'h400;
	localparam logic [11:0] DCIM_A_STAT1 = 12'h440;
	localparam logic [11:0] DCIM_A_IRQ_STAT = 12'h480;
	localparam logic [11:0] DCIM_A_IRQ_CLR = 12'h484;
	localparam logic [11:0] DCIM_A_IRQ_EN = 12'h488;
	localparam logic [11:0] DCIM_A_EDGE = 12'h48C;
	localparam logic [11:0] DCIM_A_PERIPH = 12'h490;
	localparam logic [11:0] DCIM_A_PRIO = 12'h500;
	// event bits of the interrupt status register
	localparam int DCIM_EV_NMI0 = 0;
	localparam int DCIM_EV_NMI1 = 1;
	localparam int DCIM_EV_BUSERR = 2;
	localparam int DCIM_EV_W = 3;
	// one bus request as taken in the setup cycle
	typedef struct packed {
		logic [11:0] addr;
		logic write;
		logic [31:0] wdata;
	} dcim_apb_req_t;
	// fixed priority of each core line
	function automatic logic [2:0] dcim_prio(input logic [4:0] line);
		logic [2:0] p;
		p = 3'h1;
		unique case (line)
			5'h0B, 5'h0F, 5'h16, 5'h17, 5'h1B, 5'h1D: p = 3'h3;
			5'h0E: p = DCIM_PRIO_NMI;
			5'h10, 5'h1A, 5'h1F: p = 3'h5;
			5'h13, 5'h14, 5'h15: p = 3'h2;
			5'h18, 5'h19, 5'h1C, 5'h1E: p = 3'h4;
			default: p = 3'h1;
		endcase
		return p;
	endfunction : dcim_prio
endpackage : dcim_pkg

// file: rtl/dcim_core_map.sv
`timescale 1ns/1ps
// routing of all sources onto the 32 lines of one core
module dcim_core_map #(
	parameter int NUM_SRC = dcim_pkg::DCIM_SRC_DEF
) (
	// sources and their routes for this core
	input wire logic [NUM_SRC-1:0] src,
	input wire logic [NUM_SRC-1:0][4:0] route,
	// mask from the process_id_controller
	input wire logic nmi_mask,
	// core lines and a blocked-nmi flag
	output logic [31:0] lines,
	output logic nmi_hit
);
	// one OR tree per line; internal lines never reach the core
	for (genvar l = 0; l < dcim_pkg::DCIM_LINES; l++) begin : g_line
		logic any;
		always_comb begin
			any = 1'b0;
			for (int s = 0; s < NUM_SRC; s++) begin
				if (route[s] == 5'(l)) begin
					any = any | src[s];
				end
			end
		end
		if (dcim_pkg::DCIM_PERIPH_MASK[l] == 1'b0) begin : g_int
			assign lines[l] = 1'b0;
		end else if (5'(l) == dcim_pkg::DCIM_NMI_LINE) begin : g_nmi
			// mask holds back the whole nmi line
			assign lines[l] = any & ~nmi_mask;
		end else begin : g_per
			assign lines[l] = any;
		end
	end
	// report a source that the mask is holding back
	assign nmi_hit = g_line[dcim_pkg::DCIM_NMI_LINE].any & nmi_mask;
endmodule : dcim_core_map

// file: rtl/dcim_irq.sv
`timescale 1ns/1ps
// sticky event bits, enable mask and level interrupt
module dcim_irq #(
	parameter int EW = dcim_pkg::DCIM_EV_W
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// events and software writes
	input wire logic [EW-1:0] ev,
	input wire logic clr_we,
	input wire logic en_we,
	input wire logic [EW-1:0] wdata,
	// state and interrupt
	output logic [EW-1:0] stat_r,
	output logic [EW-1:0] en_r,
	output logic irq_r
);
	// a new event beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= '0;
		end else begin
			stat_r <= (stat_r & ~(clr_we ? wdata : '0)) | ev;
		end
	end
	// enable register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r <= '0;
		end else if (en_we) begin
			en_r <= wdata;
		end
	end
	// level output, one cycle behind the status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(stat_r & en_r);
		end
	end
	chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		irq_r == $past(|(stat_r & en_r))) else $error("irq level wrong");
	chk_event_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		ev[0] |=> stat_r[0]) else $error("event bit not set");
endmodule : dcim_irq

// file: bench/dcim_pid_model.sv
`timescale 1ns/1ps
// process_id_controller stand-in: one registered mask per core
module dcim_pid_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// mask requests from the bench, bit0 first_core
	input wire logic [1:0] req,
	// masks toward the matrix
	output logic [1:0] nmi_mask
);
	// masks fall in reset so nothing stays blocked by accident
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_mask <= 2'h0;
		end else begin
			nmi_mask <= req;
		end
	end
endmodule : dcim_pid_model

// file: bench/dual_core_interrupt_matrix_bench.sv
`timescale 1ns/1ps
module dual_core_interrupt_matrix_bench;
	// bus, pins and bookkeeping
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, l0, l1, q;
	logic [68:0] src;
	logic [1:0] req, mask;
	int errors, n_checks, cyc;
	// one row: source, route per core, mask request, expected lines
	typedef struct packed {
		logic [6:0] s;
		logic [4:0] r0, r1;
		logic [1:0] m;
		logic [31:0] e0, e1;
	} dcim_row_t;
	dcim_row_t rows [10];
	dcim_matrix #(.NUM_SRC(69)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_i(src), .nmi_mask_i(mask),
		.first_core_line(l0), .second_core_line(l1), .irq(irq));
	dcim_pid_model pid (.pclk(pclk), .presetn(presetn), .req(req), .nmi_mask(mask));
	// free-running clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// hang guard, well above the few hundred cycles used
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			wrap_up();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one transfer; an idle edge follows so psel is never set twice in a step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// read and compare data and error flag
	task rd(input logic [11:0] a, input logic [31:0] x, input logic ex);
		apb(1'b0, a, 32'h0);
		chk(q, x);
		chk(32'(e), 32'(ex));
	endtask : rd
	task wrap_up;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, src, req} = '0;
		{errors, n_checks, cyc} = '0;
		rows = '{'{7'h00, 5'h00, 5'h1F, 2'h0, 32'h00000001, 32'h80000000},
			'{7'h35, 5'h05, 5'h08, 2'h0, 32'h00000020, 32'h00000100},
			'{7'h40, 5'h0A, 5'h1E, 2'h0, 32'h00000400, 32'h40000000},
			'{7'h44, 5'h0E, 5'h0E, 2'h1, 32'h00000000, 32'h00004000},
			'{7'h05, 5'h06, 5'h1D, 2'h0, 32'h00000000, 32'h00000000},
			'{7'h07, 5'h0B, 5'h10, 2'h0, 32'h00000000, 32'h00000000},
			'{7'h09, 5'h0F, 5'h07, 2'h0, 32'h00000000, 32'h00000000},
			'{7'h0A, 5'h1C, 5'h16, 2'h0, 32'h10000000, 32'h00400000},
			'{7'h0B, 5'h11, 5'h1A, 2'h0, 32'h00020000, 32'h04000000},
			'{7'h44, 5'h0E, 5'h0E, 2'h2, 32'h00004000, 32'h00000000}};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h0A0, 32'h6, 1'b0);
		// ordinary routing cases; mask settles before the source rises
		foreach (rows[i]) begin
			req <= rows[i].m;
			apb(1'b1, 12'(rows[i].s) * 12'h4, 32'(rows[i].r0));
			apb(1'b1, 12'h200 + 12'(rows[i].s) * 12'h4, 32'(rows[i].r1));
			src <= 69'h1 << rows[i].s;
			repeat (3) @(posedge pclk);
			chk(l0, rows[i].e0);
			chk(l1, rows[i].e1);
			rd(12'h400 + 12'({rows[i].s[6:5], 2'h0}), 32'h1 << rows[i].s[4:0], 1'b0);
			rd(12'h440 + 12'({rows[i].s[6:5], 2'h0}), 32'h1 << rows[i].s[4:0], 1'b0);
			src <= '0;
		end
		req <= 2'h0;
		// two sources share line 3 of the first core
		apb(1'b1, 12'h004, 32'h3);
		apb(1'b1, 12'h008, 32'h3);
		rd(12'h004, 32'h3, 1'b0);
		for (int k = 0; k < 4; k++) begin
			src <= 69'(k) << 1;
			repeat (2) @(posedge pclk);
			chk(l0, (k == 0) ? 32'h0 : 32'h8);
		end
		// masked nmi left sticky events; interrupt only once enabled
		rd(12'h480, 32'h3, 1'b0);
		chk(32'(irq), 32'h0);
		apb(1'b1, 12'h488, 32'h1);
		@(posedge pclk);
		chk(32'(irq), 32'h1);
		apb(1'b1, 12'h484, 32'h3);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0);
		// unmapped address is refused and logged but stays masked
		rd(12'hFFC, 32'h0, 1'b1);
		rd(12'h480, 32'h4, 1'b0);
		chk(32'(irq), 32'h0);
		// read-only class words ignore writes
		apb(1'b1, 12'h48C, 32'h0);
		rd(12'h48C, 32'h50400400, 1'b0);
		rd(12'h490, 32'hDFFE773F, 1'b0);
		rd(12'h500, 32'h1, 1'b0);
		rd(12'h54C, 32'h2, 1'b0);
		rd(12'h56C, 32'h3, 1'b0);
		rd(12'h560, 32'h4, 1'b0);
		rd(12'h568, 32'h5, 1'b0);
		rd(12'h538, 32'h7, 1'b0);
		// reset in mid-run drops lines and reparks routes
		src <= 69'h2;
		repeat (3) @(posedge pclk);
		chk(l0, 32'h8);
		presetn <= 1'b0;
		@(posedge pclk);
		chk(l0, 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h004, 32'h6, 1'b0);
		chk(l0, 32'h0);
		wrap_up();
	end
endmodule : dual_core_interrupt_matrix_bench
